//--- rtl/fault_report_defs.vh
// Purpose: constants shared by the fault reporting design files
// Assumes: 32-bit register words on an AXI4-Lite slave
// Notes:   register offsets are byte addresses
`ifndef FAULT_REPORT_DEFS_VH
`define FAULT_REPORT_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_CTRL_ZERO   8'h00
`define OFS_CTRL_FOUR   8'h04
`define OFS_FAULT_ADDR  8'h08
`define OFS_ERR_CODE    8'h0c
`define OFS_FP_STATUS   8'h10
`define OFS_FP_MASK     8'h14
`define OFS_FP_IP       8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define B0_PAGING       0
`define B0_WRITE_PROT   1
`define B0_NUM_ERR_EN   5
`define B4_LARGE_PAGE   0
`define B4_EXT_ADDR     1
`define B4_NO_EXEC      2
`define EC_PRESENT      0
`define EC_WRITE        1
`define EC_USER         2
`define EC_RESERVED_HIT_FLAG         3
`define EC_FETCH        4
`define FPS_PENDING     7

// ----------------------------------------------------------------
// reset values, vectors, answers, task switch stages
// ----------------------------------------------------------------
`define RST_CTRL_ZERO   32'h0000_0000
`define RST_CTRL_FOUR   32'h0000_0000
`define RST_FP_MASK     7'h7f
`define VEC_XLAT        8'h0e
`define VEC_FP          8'h10
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define TS_NEW_DESC     3'h4
`define TS_NEW_LDT      3'h5
`define TS_IDLE         3'h0

`endif

//--- rtl/xlat_fault_check.v
// Purpose: classify a translation attempt and build its error code
// Assumes: entry attributes are the combined walk result
// Notes:   purely combinational, registered by the caller
`include "fault_report_defs.vh"

module xlat_fault_check (
    input  wire        req,
    input  wire        paging_en,
    input  wire        write_prot,
    input  wire        large_page_en,
    input  wire        ext_addr_en,
    input  wire        no_exec_en,
    input  wire        is_write,
    input  wire        is_user,
    input  wire        is_fetch,
    input  wire        ent_present,
    input  wire        ent_user,
    input  wire        ent_writable,
    input  wire        ent_reserved_hit_flag,
    input  wire        ent_no_exec,
    output wire        fault,
    output wire        prot_viol,
    output wire [31:0] code
);
    wire reserved_hit_flag_hit;
    wire nx_hit;
    wire rights;

    // reserved bits only count with large pages or extended addresses
    assign reserved_hit_flag_hit  = ent_present & ent_reserved_hit_flag & (large_page_en | ext_addr_en);
    assign nx_hit    = ent_present & is_fetch & ent_no_exec & no_exec_en;
    assign rights    = ent_present & ((is_user & ~ent_user) |
                       (is_write & ~ent_writable & (is_user | write_prot)) | nx_hit);
    assign fault     = req & paging_en & (~ent_present | rights | reserved_hit_flag_hit);
    assign prot_viol = fault & rights;

    // error code layout, upper bits zero
    assign code = {27'h0,
                   is_fetch & no_exec_en,
                   reserved_hit_flag_hit,
                   is_user,
                   is_write,
                   ent_present};
endmodule

//--- rtl/fp_error_tracker.v
// Purpose: floating-point error flags, masks and deferred reporting
// Assumes: flag order stack, arith, zero, denormal, over, under, inexact
// Notes:   software clears flags by writing ones
`include "fault_report_defs.vh"

module fp_error_tracker (
    input  wire        clk,
    input  wire        rst,
    input  wire        err_valid,
    input  wire [6:0]  err_type,
    input  wire [31:0] err_ip,
    input  wire        num_err_en,
    input  wire        mask_we,
    input  wire [6:0]  mask_wdata,
    input  wire        flag_clr,
    input  wire [6:0]  flag_clr_bits,
    input  wire        take,
    output reg  [6:0]  flags_q,
    output reg  [6:0]  mask_q,
    output reg  [31:0] ip_q,
    output wire        pending,
    output wire        masked_hit
);
    wire [6:0] unmasked;

    assign unmasked   = err_type & ~mask_q;
    assign masked_hit = err_valid & (|(err_type & mask_q)) & ~(|unmasked);
    // pending only with numeric error reporting enabled
    assign pending    = num_err_en & (|(flags_q & ~mask_q));

    // sticky flags, a new error wins over a clear in the same cycle
    always @(posedge clk) begin
        if (rst) begin
            flags_q <= 7'h00;
            mask_q  <= `RST_FP_MASK;
            ip_q    <= 32'h0000_0000;
        end else begin
            flags_q <= (flags_q & ~({7{flag_clr}} & flag_clr_bits)) |
                       ({7{err_valid}} & err_type);
            if (mask_we) begin
                mask_q <= mask_wdata;
            end
            if (err_valid & (|unmasked)) begin
                ip_q <= err_ip;
            end
        end
    end
endmodule

//--- rtl/fault_report_unit.v
// Purpose: translation fault and floating-point error reporting
// Assumes: core side inputs share CLK, registers over AXI4-Lite
// Notes:   one exception is reported per EXC_VALID pulse
// Function
// - code bit 0: zero for not-present, one for rights or reserved hit
// - code bit 1: zero for read, one for write
// - code bit 2: one in user mode, zero in supervisor mode
// - reserved hit flag set when large page or extended address enabled
// - fetch flag set for fetch faults, reserved when no-execute off
// - capture faulting linear address and push the special error code
// - fault address overwritten on every fault, even during delivery
// - protection violation sets the directory entry accessed flag
// - saved pointer is faulting instruction, which is not executed
// - faults reading new descriptors or table use new task first pointer
// - task switch faults load full new state before raising
// - half switched stack used only by same privilege same task handler
// - vector 16 only with numeric error enable set
// - seven error types each with status flag and mask bit
// - masked error gives default result, no exception
// - unmasked error flagged, raised at next waiting instruction
// - pending errors checked on waiting, ignored on non-waiting
// - floating-point error exception pushes no error code
// - saved pointer is waiting instruction, fault address kept apart
// - translation fault delivered as vector 14, restartable fault
// - fault on not-present, user on supervisor, forbidden write
`include "fault_report_defs.vh"

module fault_report_unit (
    input  wire        CLK,
    input  wire        RST,
    // axi4-lite slave
    input  wire [7:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [7:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    // translation attempt
    input  wire        XLAT_VALID,
    input  wire [31:0] XLAT_ADDR,
    input  wire [31:0] XLAT_IP,
    input  wire        XLAT_WRITE,
    input  wire        XLAT_USER,
    input  wire        XLAT_FETCH,
    input  wire        ENT_PRESENT,
    input  wire        ENT_USER,
    input  wire        ENT_WRITABLE,
    input  wire        ENT_RESERVED_HIT_FLAG,
    input  wire        ENT_NO_EXEC,
    // task switch and stack context
    input  wire [2:0]  TS_STAGE,
    input  wire [31:0] TS_NEW_IP,
    input  wire        STACK_HALF,
    input  wire        HANDLER_SAME_PRIV,
    // floating-point side
    input  wire        FP_ERR_VALID,
    input  wire [6:0]  FP_ERR_TYPE,
    input  wire [31:0] FP_ERR_IP,
    input  wire        FP_INSN_VALID,
    input  wire        FP_INSN_WAITING,
    input  wire [31:0] FP_INSN_IP,
    // exception delivery
    output reg         EXC_VALID,
    output reg  [7:0]  EXC_VECTOR,
    output reg         EXC_HAS_CODE,
    output reg  [31:0] EXC_CODE,
    output reg  [31:0] EXC_SAVED_IP,
    output reg         EXC_KEEP_STACK,
    output reg         INSN_ABORT,
    output reg         TS_LOAD_ALL,
    output reg         SET_DIR_ACCESSED,
    output reg         FP_DEFAULT_RESULT
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_LOAD = 1'b1;

    reg        st_q;
    reg        st_d;
    reg [31:0] ctrl0_q;
    reg [31:0] ctrl4_q;
    reg [31:0] fault_addr_q;
    reg [31:0] err_code_q;
    reg [31:0] hold_ip_q;
    reg        hold_keep_q;
    reg [7:0]  aw_addr_q;
    reg        aw_full_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;
    reg        w_full_q;

    wire        fault;
    wire        prot_viol;
    wire [31:0] code;
    wire [6:0]  fp_flags;
    wire [6:0]  fp_mask;
    wire [31:0] fp_ip;
    wire        fp_pending;
    wire        fp_masked_hit;
    wire        wr_go;
    wire        mask_we;
    wire        flag_clr;
    wire        in_ts;
    wire        new_ctx;
    wire        fp_take;
    wire        ne_en;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // merge write data into a register by byte strobes
    function [31:0] apply_strb;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer i;
        begin
            apply_strb = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    apply_strb[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    // true for word aligned offsets that hold a register
    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'h0) && (a <= `OFS_FP_IP);
        end
    endfunction

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    xlat_fault_check u_check (
        .req           (XLAT_VALID),
        .paging_en     (ctrl0_q[`B0_PAGING]),
        .write_prot    (ctrl0_q[`B0_WRITE_PROT]),
        .large_page_en (ctrl4_q[`B4_LARGE_PAGE]),
        .ext_addr_en   (ctrl4_q[`B4_EXT_ADDR]),
        .no_exec_en    (ctrl4_q[`B4_NO_EXEC]),
        .is_write      (XLAT_WRITE),
        .is_user       (XLAT_USER),
        .is_fetch      (XLAT_FETCH),
        .ent_present   (ENT_PRESENT),
        .ent_user      (ENT_USER),
        .ent_writable  (ENT_WRITABLE),
        .ent_reserved_hit_flag      (ENT_RESERVED_HIT_FLAG),
        .ent_no_exec   (ENT_NO_EXEC),
        .fault         (fault),
        .prot_viol     (prot_viol),
        .code          (code)
    );

    fp_error_tracker u_fp (
        .clk           (CLK),
        .rst           (RST),
        .err_valid     (FP_ERR_VALID),
        .err_type      (FP_ERR_TYPE),
        .err_ip        (FP_ERR_IP),
        .num_err_en    (ne_en),
        .mask_we       (mask_we),
        .mask_wdata    (w_data_q[6:0]),
        .flag_clr      (flag_clr),
        .flag_clr_bits (w_data_q[6:0]),
        .take          (fp_take),
        .flags_q       (fp_flags),
        .mask_q        (fp_mask),
        .ip_q          (fp_ip),
        .pending       (fp_pending),
        .masked_hit    (fp_masked_hit)
    );

    // ------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------
    assign ne_en    = ctrl0_q[`B0_NUM_ERR_EN];
    assign in_ts    = (TS_STAGE != `TS_IDLE);
    assign new_ctx  = (TS_STAGE == `TS_NEW_DESC) || (TS_STAGE == `TS_NEW_LDT);
    // waiting instruction with pending error, non-waiting ones skip
    assign fp_take  = (st_q == ST_IDLE) & ~fault & FP_INSN_VALID &
                      FP_INSN_WAITING & fp_pending;
    assign wr_go    = aw_full_q & w_full_q & ~S_AXI_BVALID;
    assign mask_we  = wr_go & (aw_addr_q == `OFS_FP_MASK) & w_strb_q[0];
    assign flag_clr = wr_go & (aw_addr_q == `OFS_FP_STATUS) & w_strb_q[0];

    // ------------------------------------------------------------
    // delivery state machine
    // ------------------------------------------------------------
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (fault & in_ts) begin
                    st_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // exception outputs and fault capture
    always @(posedge CLK) begin
        if (RST) begin
            st_q              <= ST_IDLE;
            fault_addr_q      <= 32'h0000_0000;
            err_code_q        <= 32'h0000_0000;
            hold_ip_q         <= 32'h0000_0000;
            hold_keep_q       <= 1'b0;
            EXC_VALID         <= 1'b0;
            EXC_VECTOR        <= 8'h00;
            EXC_HAS_CODE      <= 1'b0;
            EXC_CODE          <= 32'h0000_0000;
            EXC_SAVED_IP      <= 32'h0000_0000;
            EXC_KEEP_STACK    <= 1'b0;
            INSN_ABORT        <= 1'b0;
            TS_LOAD_ALL       <= 1'b0;
            SET_DIR_ACCESSED  <= 1'b0;
            FP_DEFAULT_RESULT <= 1'b0;
        end else begin
            st_q              <= st_d;
            EXC_VALID         <= 1'b0;
            INSN_ABORT        <= 1'b0;
            TS_LOAD_ALL       <= 1'b0;
            SET_DIR_ACCESSED  <= prot_viol;
            FP_DEFAULT_RESULT <= fp_masked_hit;
            // software may load the address, a fault still wins
            if (wr_go && aw_addr_q == `OFS_FAULT_ADDR) begin
                fault_addr_q <= apply_strb(fault_addr_q, w_data_q, w_strb_q);
            end
            if (fault) begin
                fault_addr_q <= XLAT_ADDR;
                err_code_q   <= code;
                hold_ip_q    <= new_ctx ? TS_NEW_IP : XLAT_IP;
                hold_keep_q  <= STACK_HALF & HANDLER_SAME_PRIV;
            end
            if (st_q == ST_LOAD) begin
                // new task state loaded, now raise the held fault
                EXC_VALID      <= 1'b1;
                EXC_VECTOR     <= `VEC_XLAT;
                EXC_HAS_CODE   <= 1'b1;
                EXC_CODE       <= err_code_q;
                EXC_SAVED_IP   <= hold_ip_q;
                EXC_KEEP_STACK <= hold_keep_q;
            end else if (fault & in_ts) begin
                TS_LOAD_ALL <= 1'b1;
            end else if (fault) begin
                EXC_VALID      <= 1'b1;
                EXC_VECTOR     <= `VEC_XLAT;
                EXC_HAS_CODE   <= 1'b1;
                EXC_CODE       <= code;
                EXC_SAVED_IP   <= XLAT_IP;
                EXC_KEEP_STACK <= STACK_HALF & HANDLER_SAME_PRIV;
                INSN_ABORT     <= 1'b1;
            end else if (fp_take) begin
                EXC_VALID      <= 1'b1;
                EXC_VECTOR     <= `VEC_FP;
                EXC_HAS_CODE   <= 1'b0;
                EXC_CODE       <= 32'h0000_0000;
                EXC_SAVED_IP   <= FP_INSN_IP;
                EXC_KEEP_STACK <= STACK_HALF & HANDLER_SAME_PRIV;
                INSN_ABORT     <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write side
    // ------------------------------------------------------------
    // address and data taken in either order, answer after both
    always @(posedge CLK) begin
        if (RST) begin
            aw_addr_q     <= 8'h00;
            aw_full_q     <= 1'b0;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            w_full_q      <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `RESP_OKAY;
            ctrl0_q       <= `RST_CTRL_ZERO;
            ctrl4_q       <= `RST_CTRL_FOUR;
        end else begin
            if (S_AXI_AWVALID & S_AXI_AWREADY) begin
                aw_addr_q     <= S_AXI_AWADDR;
                aw_full_q     <= 1'b1;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID & S_AXI_WREADY) begin
                w_data_q     <= S_AXI_WDATA;
                w_strb_q     <= S_AXI_WSTRB;
                w_full_q     <= 1'b1;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_go) begin
                aw_full_q    <= 1'b0;
                w_full_q     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
                if (aw_addr_q == `OFS_CTRL_ZERO) begin
                    ctrl0_q <= apply_strb(ctrl0_q, w_data_q, w_strb_q);
                end
                if (aw_addr_q == `OFS_CTRL_FOUR) begin
                    ctrl4_q <= apply_strb(ctrl4_q, w_data_q, w_strb_q);
                end
            end
            if (S_AXI_BVALID & S_AXI_BREADY) begin
                S_AXI_BVALID  <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read side
    // ------------------------------------------------------------
    // one read at a time, data one cycle after the address
    always @(posedge CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= `RESP_OKAY;
        end else begin
            if (S_AXI_ARVALID & S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID  <= 1'b1;
                S_AXI_RRESP   <= mapped(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
                case (S_AXI_ARADDR)
                    `OFS_CTRL_ZERO:  S_AXI_RDATA <= ctrl0_q;
                    `OFS_CTRL_FOUR:  S_AXI_RDATA <= ctrl4_q;
                    `OFS_FAULT_ADDR: S_AXI_RDATA <= fault_addr_q;
                    `OFS_ERR_CODE:   S_AXI_RDATA <= err_code_q;
                    `OFS_FP_STATUS:  S_AXI_RDATA <= {24'h000000, fp_pending, fp_flags};
                    `OFS_FP_MASK:    S_AXI_RDATA <= {25'h0, fp_mask};
                    `OFS_FP_IP:      S_AXI_RDATA <= fp_ip;
                    default:         S_AXI_RDATA <= 32'h0000_0000;
                endcase
            end
            if (S_AXI_RVALID & S_AXI_RREADY) begin
                S_AXI_RVALID  <= 1'b0;
                S_AXI_ARREADY <= 1'b1;
            end
        end
    end
endmodule

//--- testbench/fault_report_unit_sva.sv
// Purpose: port level checks of the fault reporting unit
// Assumes: one clock, synchronous active high reset
// Notes:   bound into the design from the bench top
module fault_report_unit_sva (
    input wire        CLK,
    input wire        RST,
    input wire        XLAT_WRITE,
    input wire        XLAT_USER,
    input wire [31:0] XLAT_IP,
    input wire        ENT_PRESENT,
    input wire [2:0]  TS_STAGE,
    input wire [31:0] TS_NEW_IP,
    input wire        STACK_HALF,
    input wire        HANDLER_SAME_PRIV,
    input wire        FP_INSN_VALID,
    input wire        FP_INSN_WAITING,
    input wire [31:0] FP_INSN_IP,
    input wire        EXC_VALID,
    input wire [7:0]  EXC_VECTOR,
    input wire        EXC_HAS_CODE,
    input wire [31:0] EXC_CODE,
    input wire [31:0] EXC_SAVED_IP,
    input wire        EXC_KEEP_STACK,
    input wire        INSN_ABORT,
    input wire        TS_LOAD_ALL
);
    // ------------------------------------------------
    // direct, task switch and floating-point exception events
    // ------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_pf;
        EXC_VALID && EXC_VECTOR == 8'h0e && !$past(TS_LOAD_ALL);
    endsequence
    sequence s_mf;
        EXC_VALID && EXC_VECTOR == 8'h10;
    endsequence
    a_present_bit: assert property (s_pf |-> EXC_CODE[0] == $past(ENT_PRESENT))
        else $error("present bit wrong");
    a_dir_bit: assert property (s_pf |-> EXC_CODE[1] == $past(XLAT_WRITE))
        else $error("direction bit wrong");
    a_user_bit: assert property (s_pf |-> EXC_CODE[2] == $past(XLAT_USER))
        else $error("user bit wrong");
    a_code_fmt: assert property (s_pf |-> EXC_HAS_CODE && EXC_CODE[31:5] == 0)
        else $error("error code format wrong");
    a_xlat_ip: assert property (s_pf |-> INSN_ABORT && EXC_SAVED_IP == $past(XLAT_IP))
        else $error("saved pointer wrong");
    a_keep_stack: assert property (s_pf |-> EXC_KEEP_STACK == $past(STACK_HALF && HANDLER_SAME_PRIV))
        else $error("stack choice wrong");
    a_ts_order: assert property (TS_LOAD_ALL |=> EXC_VALID && EXC_VECTOR == 8'h0e)
        else $error("no exception after load");
    a_ts_new_ip: assert property (TS_LOAD_ALL && $past(TS_STAGE) inside {3'h4, 3'h5}
        |=> EXC_SAVED_IP == $past(TS_NEW_IP, 2)) else $error("new task pointer wrong");
    a_fp_skip: assert property (FP_INSN_VALID && !FP_INSN_WAITING
        |=> !(EXC_VALID && EXC_VECTOR == 8'h10)) else $error("non-waiting raised");
    a_fp_save: assert property (s_mf |-> !EXC_HAS_CODE && EXC_SAVED_IP == $past(FP_INSN_IP))
        else $error("fp exception state wrong");
endmodule

//--- testbench/fault_report_unit_test.sv
// Purpose: self-checking bench for the fault reporting unit
// Assumes: byte address registers, 25 MHz clock
// Notes:   each scenario task judges its own results
module fault_report_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, xv = 0, fev = 0, fiv = 0, fiw = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, xa = 0;
    logic [9:0]  xf = 0;
    logic [6:0]  fet = 0;
    logic [2:0]  ts = 0;
    wire         awready, wready, bvalid, arready, rvalid, ev, ehc, eks, tsl, fpd, sda;
    wire [1:0]   bresp, rresp;
    wire [7:0]   evec;
    wire [31:0]  rdata, ecode, instruction_pointer;
    int          n_fail = 0, cmp_count = 0, cyc = 0;
    fault_report_unit DUT (
        .CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .XLAT_VALID(xv), .XLAT_ADDR(xa), .XLAT_IP(~xa), .XLAT_WRITE(xf[5]),
        .XLAT_USER(xf[6]), .XLAT_FETCH(xf[7]), .ENT_PRESENT(xf[0]), .ENT_USER(xf[1]),
        .ENT_WRITABLE(xf[2]), .ENT_RESERVED_HIT_FLAG(xf[3]), .ENT_NO_EXEC(xf[4]), .TS_STAGE(ts),
        .TS_NEW_IP(32'h4444), .STACK_HALF(xf[8]), .HANDLER_SAME_PRIV(xf[9]),
        .FP_ERR_VALID(fev), .FP_ERR_TYPE(fet), .FP_ERR_IP({25'h0, fet}),
        .FP_INSN_VALID(fiv), .FP_INSN_WAITING(fiw), .FP_INSN_IP({28'h222, 3'h0, fiw}),
        .EXC_VALID(ev), .EXC_VECTOR(evec), .EXC_HAS_CODE(ehc), .EXC_CODE(ecode),
        .EXC_SAVED_IP(instruction_pointer), .EXC_KEEP_STACK(eks), .INSN_ABORT(), .TS_LOAD_ALL(tsl),
        .SET_DIR_ACCESSED(sda), .FP_DEFAULT_RESULT(fpd));
    // clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            final_report;
        end
    end
    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task final_report;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] r);
        logic aw, w;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        aw = 1;
        w = 1;
        while (aw | w) begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            aw = aw & !awready;
            w = w & !wready;
        end
        while (!bvalid) @(posedge clk);
        bready <= 0;
        chk(32'(bresp), 32'(r));
    endtask
    task rd(input [7:0] a, input [31:0] d, input [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge clk); while (!arready);
        arvalid <= 0;
        do @(posedge clk); while (!rvalid);
        rready <= 0;
        chk(rdata, d);
        chk(32'(rresp), 32'(r));
    endtask
    task drv(input [31:0] a, input [9:0] f);
        @(posedge clk);
        xv <= 1;
        xa <= a;
        xf <= f;
        @(posedge clk);
        xv <= 0;
        #1;
    endtask
    task fperr(input [6:0] t, input d);
        @(posedge clk);
        fev <= 1;
        fet <= t;
        @(posedge clk);
        fev <= 0;
        #1;
        chk(32'(fpd), 32'(d));
    endtask
    task ins(input w, input e);
        @(posedge clk);
        fiv <= 1;
        fiw <= w;
        @(posedge clk);
        fiv <= 0;
        #1;
        chk(32'(ev), 32'(e));
        if (e) begin
            chk(32'(evec), 32'h10);
            chk(32'(ehc), 0);
            chk(instruction_pointer, 32'h2221);
        end
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task t_regs;
        rd(8'h00, 0, 0);
        rd(8'h14, 32'h7f, 0);
        rd(8'h1c, 0, 2);
        wr(8'h1c, 1, 2);
        wr(8'h00, 32'h21, 0);
        rd(8'h00, 32'h21, 0);
        $display("register test done");
    endtask
    task t_xlat;
        static logic [9:0]  f[5] = '{10'h300, 10'h063, 10'h041, 10'h00f, 10'h097};
        static logic [31:0] c[5] = '{0, 7, 5, 9, 32'h11};
        for (int i = 0; i < 5; i++) begin
            if (i == 3) wr(8'h04, 1, 0);
            if (i == 4) wr(8'h04, 4, 0);
            drv(32'h1abc + i, f[i]);
            chk(32'(ev), 1);
            chk(32'(evec), 32'h0e);
            chk(ecode, c[i]);
            chk(instruction_pointer, ~(32'h1abc + i));
            chk(32'(eks), 32'(f[i][8] & f[i][9]));
            chk(32'(sda), 32'(c[i][0] & ~c[i][3]));
            rd(8'h08, 32'h1abc + i, 0);
        end
        $display("translation test done");
    endtask
    task t_b2b;
        drv(32'h7000, 0);
        drv(32'h8000, 0);
        rd(8'h08, 32'h8000, 0);
        drv(32'h9000, 10'h007);
        chk(32'(ev), 0);
        $display("overwrite test done");
    endtask
    task t_ts;
        @(posedge clk);
        ts <= 3'h5;
        drv(32'h6000, 0);
        chk(32'(tsl), 1);
        chk(32'(ev), 0);
        @(posedge clk);
        ts <= 0;
        #1;
        chk(32'(ev), 1);
        chk(instruction_pointer, 32'h4444);
        $display("task switch test done");
    endtask
    task t_fp;
        for (int i = 0; i < 7; i++) fperr(7'h1 << i, 1);
        rd(8'h10, 32'h7f, 0);
        wr(8'h10, 32'h7f, 0);
        wr(8'h14, 32'h7b, 0);
        fperr(7'h04, 0);
        rd(8'h10, 32'h84, 0);
        rd(8'h18, 32'h4, 0);
        ins(0, 0);
        ins(1, 1);
        wr(8'h10, 32'h7f, 0);
        wr(8'h00, 32'h01, 0);
        fperr(7'h04, 0);
        ins(1, 0);
        $display("floating-point test done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        t_regs;
        t_xlat;
        t_b2b;
        t_ts;
        t_fp;
        final_report;
    end
endmodule
bind fault_report_unit fault_report_unit_sva u_sva (.CLK, .RST, .XLAT_WRITE, .XLAT_USER,
    .XLAT_IP, .ENT_PRESENT, .TS_STAGE, .TS_NEW_IP, .STACK_HALF, .HANDLER_SAME_PRIV,
    .FP_INSN_VALID, .FP_INSN_WAITING, .FP_INSN_IP, .EXC_VALID, .EXC_VECTOR, .EXC_HAS_CODE,
    .EXC_CODE, .EXC_SAVED_IP, .EXC_KEEP_STACK, .INSN_ABORT, .TS_LOAD_ALL);
